// ==== design/acm_pkg.sv ====
package acm_pkg;
    localparam logic [1:0] MODE_REG_TRIG   = 2'h0;
    localparam logic [1:0] MODE_ONE_PULSE  = 2'h1;
    localparam logic [1:0] MODE_RESERVED   = 2'h2;
    localparam logic [1:0] MODE_PER_PULSE  = 2'h3;
    localparam logic [1:0] MODE_RESET      = MODE_REG_TRIG;
    localparam int         CLK_MHZ         = 25;
    localparam int         PWRUP_NS        = 200;
    localparam int         CONV_NS         = 3500;
    localparam int         PWRUP_CYC       = (PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int         CONV_CYC        = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int         CNT_W           = 12;
    localparam int         CHAN_W          = 11;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_PWRUP = 3'b010,
        ST_CONV  = 3'b011,
        ST_PWRDN = 3'b100
    } acm_state_t;
endpackage

// ==== design/acm_timer_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface acm_timer_if;
    import acm_pkg::*;
    logic             load;
    logic [CNT_W-1:0] count;
    logic             done;
    modport ctrl (output load, output count, input done);
    modport tmr  (input load, input count, output done);
endinterface
`default_nettype wire

// ==== design/acm_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module acm_timer
    import acm_pkg::*;
(
    input  wire logic   sys_clk_i,
    input  wire logic   rst_i,
    acm_timer_if.tmr    tif
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             done_ff;
    logic             nxt_done;

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_done = 1'b0;
        if (tif.load) begin
            nxt_cnt = tif.count;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
            nxt_done = (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign tif.done = done_ff;
endmodule
`default_nettype wire

// ==== design/acm_seq.sv ====
// Overview of operation
// - Leaving register-triggered mode mid-scan finishes all triggered conversions, then idles.
// - Busy stays high during mode change until outstanding conversions finish.
// - After pending work ends, commands follow the newly written mode.
// - Leaving single-pulse mode while awaiting first trigger: power down, idle at once.
// - Leaving single-pulse mode after sequence start: finish current conversion, then idle.
// - Leaving per-pulse mode while awaiting trigger: power down, idle, busy low.
// - Leaving per-pulse mode mid-conversion: finish that conversion, then idle.
// - Register-triggered mode: conversion write alone runs powerup, convert, powerdown.
// - Per-pulse mode: each convert-start low pulse converts exactly one channel.
`timescale 1ns/1ns
`default_nettype none
module acm_seq
    import acm_pkg::*;
#(
    parameter int CHANNELS = CHAN_W
)(
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    input  wire logic                clock_mode_select_high_i,
    input  wire logic                clock_mode_select_low_i,
    input  wire logic                mode_wr_i,
    input  wire logic                conv_wr_i,
    input  wire logic [CHANNELS-1:0] chan_sel_i,
    input  wire logic                convert_start_n_i,
    output logic                     busy_o,
    output logic                     adc_power_o,
    output logic                     conv_done_o,
    output logic [3:0]               conv_chan_o,
    output logic [1:0]               mode_o
);
    acm_timer_if tif ();
    acm_timer u_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .tif       (tif)
    );

    logic                cs_meta_ff, cs_sync_ff, cs_prev_ff;
    logic                nxt_cs_meta, nxt_cs_sync, nxt_cs_prev;
    logic                cs_fall;
    acm_state_t          state_ff, nxt_state;
    logic [1:0]          mode_ff, nxt_mode;
    logic [1:0]          run_mode_ff, nxt_run_mode;
    logic                stop_ff, nxt_stop;
    logic [CHANNELS-1:0] pend_ff, nxt_pend;
    logic [3:0]          chan_ff, nxt_chan;
    logic                busy_ff, nxt_busy;
    logic                pwr_ff, nxt_pwr;
    logic                done_ff, nxt_done;
    logic [3:0]          first_chan;

    // Two-stage synchroniser for the pin, then falling-edge detect
    always_comb begin
        nxt_cs_meta = convert_start_n_i;
        nxt_cs_sync = cs_meta_ff;
        nxt_cs_prev = cs_sync_ff;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else begin
            cs_meta_ff <= nxt_cs_meta;
            cs_sync_ff <= nxt_cs_sync;
            cs_prev_ff <= nxt_cs_prev;
        end
    end
    assign cs_fall = cs_prev_ff & ~cs_sync_ff;

    always_comb begin
        first_chan = 4'h0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (nxt_pend_src(i)) begin
                first_chan = 4'(i);
            end
        end
    end

    function automatic logic nxt_pend_src(input int idx);
        nxt_pend_src = pend_ff[idx];
    endfunction

    always_comb begin
        nxt_state    = state_ff;
        nxt_mode     = mode_ff;
        nxt_run_mode = run_mode_ff;
        nxt_stop     = stop_ff;
        nxt_pend     = pend_ff;
        nxt_chan     = chan_ff;
        nxt_busy     = busy_ff;
        nxt_pwr      = pwr_ff;
        nxt_done     = 1'b0;
        tif.load     = 1'b0;
        tif.count    = '0;
        // Mode register takes effect on the edge after the write
        if (mode_wr_i) begin
            nxt_mode = {clock_mode_select_high_i, clock_mode_select_low_i};
        end
        case (state_ff)
            ST_IDLE: begin
                nxt_busy = 1'b0;
                nxt_stop = 1'b0;
                if (conv_wr_i && chan_sel_i != '0) begin
                    nxt_pend     = chan_sel_i;
                    nxt_run_mode = mode_ff;
                    if (mode_ff == MODE_REG_TRIG) begin
                        nxt_state = ST_PWRUP;
                        nxt_busy  = 1'b1;
                        nxt_pwr   = 1'b1;
                        tif.load  = 1'b1;
                        tif.count = CNT_W'(PWRUP_CYC);
                    end else if (mode_ff != MODE_RESERVED) begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // Busy falls one cycle after a per-pulse conversion ends
                nxt_busy = 1'b0;
                // Armed but not triggered: drop straight to idle, ADC off
                if (mode_ff != run_mode_ff) begin
                    nxt_state = ST_IDLE;
                    nxt_pwr   = 1'b0;
                    nxt_busy  = 1'b0;
                    nxt_pend  = '0;
                end else if (cs_fall) begin
                    nxt_state = ST_PWRUP;
                    nxt_busy  = 1'b1;
                    nxt_pwr   = 1'b1;
                    tif.load  = 1'b1;
                    tif.count = CNT_W'(PWRUP_CYC);
                end
            end
            ST_PWRUP: begin
                // A register-triggered scan always runs to its end
                if (mode_ff != run_mode_ff && run_mode_ff != MODE_REG_TRIG) begin
                    nxt_stop = 1'b1;
                end
                if (tif.done) begin
                    nxt_state = ST_CONV;
                    nxt_chan  = first_chan;
                    tif.load  = 1'b1;
                    tif.count = CNT_W'(CONV_CYC);
                end
            end
            ST_CONV: begin
                if (mode_ff != run_mode_ff && run_mode_ff == MODE_ONE_PULSE) begin
                    nxt_stop = 1'b1;
                end
                if (tif.done) begin
                    nxt_done = 1'b1;
                    nxt_pend = pend_ff & ~(CHANNELS'(1) << chan_ff);
                    if (run_mode_ff == MODE_PER_PULSE) begin
                        // One channel per pulse; a mode change ends here anyway
                        if (nxt_pend == '0 || mode_ff != run_mode_ff) begin
                            nxt_state = ST_PWRDN;
                        end else begin
                            nxt_state = ST_WAIT;
                        end
                    end else if (nxt_pend == '0 || stop_ff
                                 || (mode_ff != run_mode_ff && run_mode_ff == MODE_ONE_PULSE)) begin
                        nxt_state = ST_PWRDN;
                    end else begin
                        // Short settle between channels; the ADC stays powered
                        nxt_state = ST_PWRUP;
                        tif.load  = 1'b1;
                        tif.count = 12'h001;
                    end
                end
            end
            ST_PWRDN: begin
                nxt_state = ST_IDLE;
                nxt_pwr   = 1'b0;
                nxt_busy  = 1'b0;
                nxt_pend  = '0;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // Stop flag never survives a register-triggered channel
        if (state_ff == ST_CONV && tif.done && run_mode_ff == MODE_REG_TRIG) begin
            nxt_stop = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff    <= ST_IDLE;
            mode_ff     <= MODE_RESET;
            run_mode_ff <= MODE_RESET;
            stop_ff     <= 1'b0;
            pend_ff     <= '0;
            chan_ff     <= 4'h0;
            busy_ff     <= 1'b0;
            pwr_ff      <= 1'b0;
            done_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            mode_ff     <= nxt_mode;
            run_mode_ff <= nxt_run_mode;
            stop_ff     <= nxt_stop;
            pend_ff     <= nxt_pend;
            chan_ff     <= nxt_chan;
            busy_ff     <= nxt_busy;
            pwr_ff      <= nxt_pwr;
            done_ff     <= nxt_done;
        end
    end

    assign busy_o      = busy_ff;
    assign adc_power_o = pwr_ff;
    assign conv_done_o = done_ff;
    assign conv_chan_o = chan_ff;
    assign mode_o      = mode_ff;
endmodule
`default_nettype wire

// ==== tb/acm_seq_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module acm_seq_monitor
    import acm_pkg::*;
#(
    parameter int CHANNELS = CHAN_W
)(
    input wire logic                sys_clk_i,
    input wire logic                rst_i,
    input wire logic                clock_mode_select_high_i,
    input wire logic                clock_mode_select_low_i,
    input wire logic                mode_wr_i,
    input wire logic                conv_wr_i,
    input wire logic [CHANNELS-1:0] chan_sel_i,
    input wire logic                busy_o,
    input wire logic                adc_power_o,
    input wire logic                conv_done_o,
    input wire logic [1:0]          mode_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] new_mode;
    logic       changing;
    assign new_mode = {clock_mode_select_high_i, clock_mode_select_low_i};
    assign changing = mode_wr_i && new_mode != mode_o;
    property p_mode_take; mode_wr_i |=> mode_o == $past(new_mode); endproperty
    a_mode_take: assert property (p_mode_take) else $error("mode not taken");
    property p_conv_start;
        conv_wr_i && !mode_wr_i && !busy_o && mode_o == MODE_REG_TRIG && chan_sel_i != '0
            |=> busy_o && adc_power_o;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("scan not started");
    property p_done_in_busy; conv_done_o |-> busy_o; endproperty
    a_done_in_busy: assert property (p_done_in_busy) else $error("done while idle");
    property p_done_pulse; conv_done_o |=> !conv_done_o [*8]; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too close");
    property p_wait_busy;
        changing && !busy_o && mode_o == MODE_PER_PULSE |=> !busy_o [*3];
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("busy on wait exit");
    property p_wait_power; changing && !busy_o |-> ##[1:3] !adc_power_o; endproperty
    a_wait_power: assert property (p_wait_power) else $error("power kept");
    property p_busy_fall;
        $fell(busy_o) |-> $past(conv_done_o) || $past(conv_done_o, 2) || $past(conv_done_o, 3);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell early");
    property p_finish_cur;
        changing && busy_o && !$past(conv_done_o) && !$past(conv_done_o, 2)
            |-> ##[0:120] conv_done_o;
    endproperty
    a_finish_cur: assert property (p_finish_cur) else $error("conversion dropped");
    c_busy_change: cover property (changing && busy_o);
    c_idle_change: cover property (changing && !busy_o);
    c_done_pp: cover property (conv_done_o && mode_o == MODE_PER_PULSE);
endmodule
bind acm_seq acm_seq_monitor #(.CHANNELS(CHANNELS)) acm_seq_monitor_inst (.sys_clk_i,
    .rst_i, .clock_mode_select_high_i, .clock_mode_select_low_i, .mode_wr_i, .conv_wr_i,
    .chan_sel_i, .busy_o, .adc_power_o, .conv_done_o, .mode_o);
`default_nettype wire

// ==== tb/acm_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module acm_host_model
    import acm_pkg::*;
(
    input  wire logic        sys_clk_i,
    output logic [1:0]       mode_sel_o,
    output logic             mode_wr_o,
    output logic             conv_wr_o,
    output logic [CHAN_W-1:0] chan_o,
    output logic             cnv_n_o
);
    initial begin
        mode_sel_o = MODE_RESET;
        mode_wr_o = 1'b0;
        conv_wr_o = 1'b0;
        chan_o = '0;
        cnv_n_o = 1'b1;
    end
    task automatic set_mode(input logic [1:0] m);
        if (m == MODE_RESERVED) return;
        @(posedge sys_clk_i) #1;
        mode_sel_o = m;
        mode_wr_o = 1'b1;
        @(posedge sys_clk_i) #1;
        mode_wr_o = 1'b0;
    endtask
    task automatic conv(input logic [CHAN_W-1:0] ch);
        @(posedge sys_clk_i) #1;
        chan_o = ch;
        conv_wr_o = 1'b1;
        @(posedge sys_clk_i) #1;
        conv_wr_o = 1'b0;
    endtask
    // One low pulse per trigger, held well past the synchroniser
    task automatic pulse;
        @(posedge sys_clk_i) #1;
        cnv_n_o = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #1 cnv_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== tb/adc_clock_mode_switch_control_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module adc_clock_mode_switch_control_bench;
    import acm_pkg::*;
    logic sys_clk_i, rst_i, mode_wr, conv_wr, cnv_n, busy_o, adc_power_o, conv_done_o;
    logic [1:0] mode_sel, mode_o;
    logic [3:0] conv_chan_o;
    logic [CHAN_W-1:0] chan;
    logic [7:0] n;
    int bad_count, n_compared;
    acm_host_model acm_host_model_inst (.sys_clk_i, .mode_sel_o(mode_sel),
        .mode_wr_o(mode_wr), .conv_wr_o(conv_wr), .chan_o(chan), .cnv_n_o(cnv_n));
    acm_seq acm_seq_inst (.sys_clk_i, .rst_i, .clock_mode_select_high_i(mode_sel[1]),
        .clock_mode_select_low_i(mode_sel[0]), .mode_wr_i(mode_wr), .conv_wr_i(conv_wr),
        .chan_sel_i(chan), .convert_start_n_i(cnv_n), .busy_o, .adc_power_o,
        .conv_done_o, .conv_chan_o, .mode_o);
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_busy;
        repeat (50) begin
            @(negedge sys_clk_i);
            if (busy_o === 1'b1) break;
        end
    endtask
    // Count finished conversions until the sequencer drops busy
    task automatic drain(output logic [7:0] cnt);
        cnt = 8'h00;
        repeat (1500) begin
            @(negedge sys_clk_i);
            if (conv_done_o === 1'b1) cnt++;
            if (busy_o === 1'b0) break;
        end
        check("busy after drain", 8'(busy_o), 8'h00);
    endtask
    task automatic t_scan00;
        acm_host_model_inst.conv(11'h007);
        @(negedge sys_clk_i);
        check("busy on write", 8'(busy_o), 8'h01);
        repeat (30) @(posedge sys_clk_i);
        acm_host_model_inst.set_mode(MODE_PER_PULSE);
        check("mode", 8'(mode_o), 8'(MODE_PER_PULSE));
        drain(n);
        check("scan count", n, 8'h03);
        check("scan last chan", 8'(conv_chan_o), 8'h02);
        check("power after scan", 8'(adc_power_o), 8'h00);
    endtask
    task automatic t_wait11;
        acm_host_model_inst.conv(11'h001);
        repeat (5) @(posedge sys_clk_i);
        acm_host_model_inst.set_mode(MODE_ONE_PULSE);
        repeat (3) @(negedge sys_clk_i);
        check("busy pp exit", 8'(busy_o), 8'h00);
        check("power pp exit", 8'(adc_power_o), 8'h00);
        acm_host_model_inst.pulse();
        repeat (3) @(negedge sys_clk_i);
        check("pulse after exit", 8'(busy_o), 8'h00);
    endtask
    task automatic t_wait01;
        acm_host_model_inst.conv(11'h001);
        repeat (5) @(posedge sys_clk_i);
        acm_host_model_inst.set_mode(MODE_REG_TRIG);
        repeat (3) @(negedge sys_clk_i);
        check("power op exit", 8'(adc_power_o), 8'h00);
        acm_host_model_inst.conv(11'h001);
        @(negedge sys_clk_i);
        check("new mode start", 8'(busy_o), 8'h01);
        drain(n);
        check("one conv", n, 8'h01);
    endtask
    task automatic t_mid(input logic [1:0] m, input int pulses);
        acm_host_model_inst.set_mode(m);
        acm_host_model_inst.conv(11'h007);
        repeat (pulses) begin
            acm_host_model_inst.pulse();
            wait_busy();
            drain(n);
            check("per pulse", n, 8'h01);
        end
        acm_host_model_inst.pulse();
        wait_busy();
        repeat (20) @(posedge sys_clk_i);
        acm_host_model_inst.set_mode(MODE_REG_TRIG);
        drain(n);
        check("finish current", n, 8'h01);
        check("last chan", 8'(conv_chan_o), 8'(pulses));
        check("power after stop", 8'(adc_power_o), 8'h00);
    endtask
    initial begin
        bad_count = 0;
        n_compared = 0;
        rst_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        @(negedge sys_clk_i);
        check("reset mode", 8'(mode_o), 8'(MODE_RESET));
        t_scan00();
        t_wait11();
        t_wait01();
        t_mid(MODE_ONE_PULSE, 0);
        t_mid(MODE_PER_PULSE, 1);
        end_of_test();
    end
    initial begin
        #800000;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
